// ### cdsb_map.vh
// Constants for the clear, decrement, skip and branch execution unit.
// Function
// - Clear-file writes zero to file register 0..127, always sets zero flag.
// - Decrement subtracts one; destination bit 0 goes to working, 1 to file.
// - Clear-working loads zero into working register and sets zero flag.
// - Decrement-skip decrements, routes by destination bit, keeps flags.
// - Decrement-skip with zero result runs next word taken as no-op; two cycles.
// - Increment-skip adds one, routes by destination bit, changes no flag.
// - Increment-skip with zero result runs next word taken as no-op; two cycles.
// - Branch loads 11-bit immediate into counter 10:0, latch 6:3 into 14:11.
// - Branch takes two instruction cycles and leaves all flags unaffected.
// - Or-literal ORs working with 8-bit literal into working, updates zero.
`ifndef CDSB_MAP_VH
`define CDSB_MAP_VH

// Instruction word layout.
`define CDSB_INSTR_W        14
`define CDSB_OP_HI          13
`define CDSB_OP_LO          8
`define CDSB_DEST_BIT       7
`define CDSB_FADDR_HI       6
`define CDSB_FADDR_LO       0
`define CDSB_LIT_HI         7
`define CDSB_LIT_HI_BR      10
`define CDSB_BR_HI          13
`define CDSB_BR_LO          11

// Operation codes in bits 13:8, branch code in bits 13:11.
`define CDSB_OP_CLEAR_WORK  6'h10
`define CDSB_OP_CLEAR_FILE  6'h11
`define CDSB_OP_DEC_FILE    6'h12
`define CDSB_OP_DEC_SKIP    6'h13
`define CDSB_OP_INC_SKIP    6'h14
`define CDSB_OP_OR_LIT      6'h15
`define CDSB_OP_BRANCH      3'h7

// Destination bit values.
`define CDSB_DEST_WORK      1'h0
`define CDSB_DEST_FILE      1'h1

// Counter layout: latch bits 6:3 feed counter bits 14:11.
`define CDSB_PC_W           15
`define CDSB_LATCH_W        7
`define CDSB_LATCH_HI       6
`define CDSB_LATCH_LO       3

// Reset values.
`define CDSB_W_RESET        8'h00
`define CDSB_PC_RESET       15'h0000
`define CDSB_Z_RESET        1'h0

// Clock cycles of CORE_CLK in one instruction cycle.
`define CDSB_CYCLE_CLKS     2

`endif

// ### cdsb_file_mem.v
// File register memory with a registered read port and one write port.
module cdsb_file_mem #(
    parameter ADDR_W = 7,
    parameter DATA_W = 8
) (
    input  wire              clk,
    input  wire              rd_en,
    input  wire [ADDR_W-1:0] rd_addr,
    output reg  [DATA_W-1:0] rd_data,
    input  wire              wr_en,
    input  wire [ADDR_W-1:0] wr_addr,
    input  wire [DATA_W-1:0] wr_data
);

    reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Read and write share the edge; the read data register samples the array before the write lands.
    always @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// ### cdsb_phase_div.v
// Divider that splits CORE_CLK into instruction cycle phase pulses.
`include "cdsb_map.vh"
module cdsb_phase_div #(
    parameter CYCLE_CLKS = `CDSB_CYCLE_CLKS
) (
    input  wire clk,
    input  wire rst,
    output reg  start_q,
    output reg  exec_q
);

    localparam CW = 4;
    localparam [CW-1:0] LAST = CYCLE_CLKS[CW-1:0] - 4'h1;

    reg [CW-1:0] cnt_q;
    reg [CW-1:0] cnt_d;

    // Next phase count, wrapping at the end of each instruction cycle.
    always @*
    begin
        if (cnt_q == LAST)
        begin
            cnt_d = {CW{1'b0}};
        end
        else
        begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    // Start pulse marks the first clock, exec pulse the last clock.
    always @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q   <= {CW{1'b0}};
            start_q <= 1'b0;
            exec_q  <= 1'b0;
        end
        else
        begin
            cnt_q   <= cnt_d;
            start_q <= (cnt_d == {CW{1'b0}});
            exec_q  <= (cnt_d == LAST);
        end
    end

endmodule

// ### cdsb_exec_core.v
// Execution unit for clear, decrement, skip, branch and or-literal ops.
`include "cdsb_map.vh"
module cdsb_exec_core #(
    parameter CYCLE_CLKS = `CDSB_CYCLE_CLKS
) (
    input  wire                        CORE_CLK,
    input  wire                        RST,
    input  wire                        INSTR_VALID,
    input  wire [`CDSB_INSTR_W-1:0]    INSTR_CODE,
    input  wire [`CDSB_LATCH_W-1:0]    PC_HIGH_LATCH,
    output wire                        INSTR_READY,
    output reg  [7:0]                  W_REG,
    output reg                         ZERO_FLAG,
    output reg  [`CDSB_PC_W-1:0]       PROGRAM_COUNTER,
    output reg                         PC_LOADED,
    output reg                         SKIP_TAKEN,
    output reg                         DISCARDED,
    output reg                         RETIRED,
    output reg                         UNKNOWN_OP,
    output reg                         FILE_WE,
    output reg  [6:0]                  FILE_ADDR,
    output reg  [7:0]                  FILE_WDATA
);

    // Zero test on an 8-bit result, shared by the decrement and or-literal ops
    // that write the zero flag and by both skip tests; the clears set it directly.
    function zero8;
        input [7:0] v;
        begin
            zero8 = (v == 8'h00);
        end
    endfunction

    // Counter advance by one instruction word; the top bit wraps silently,
    // so the counter rolls over from the last word back to word zero.
    function [`CDSB_PC_W-1:0] pc_next;
        input [`CDSB_PC_W-1:0] pc;
        begin
            pc_next = pc + 15'h0001;
        end
    endfunction

    // Phase pulses and the registered file read data.
    wire                     start_en;
    wire                     exec_en;
    wire [7:0]               f_data;

    // Fetch state: the latched word and the discard bookkeeping.
    reg  [`CDSB_INSTR_W-1:0] ir_q;
    reg                      busy_q;
    reg                      kill_q;
    reg                      nop_pend_q;

    // Next values worked out by the decoder for the exec edge.
    reg  [7:0]               w_d;
    reg                      z_d;
    reg  [`CDSB_PC_W-1:0]    pc_d;
    reg                      mem_we_d;
    reg  [7:0]               mem_wd_d;
    reg                      loaded_d;
    reg                      skip_d;
    reg                      unknown_d;
    reg  [7:0]               res_d;

    // Handshake qualifiers and the fields of the latched word.
    wire                     take_instr;
    wire                     fire;
    wire [5:0]               op;
    wire                     dest;
    wire [6:0]               faddr;
    wire [7:0]               dec_val;
    wire [7:0]               inc_val;

    // Instruction cycle phase pulses.
    // Only these pulses pace the unit; there is no second clock, and a
    // longer instruction cycle only needs a larger divider count.
    cdsb_phase_div #(
        .CYCLE_CLKS (CYCLE_CLKS)
    ) u_div (
        .clk     (CORE_CLK),
        .rst     (RST),
        .start_q (start_en),
        .exec_q  (exec_en)
    );

    // File registers, read in the first phase, written in the last.
    // A write at the exec edge lands before the next take edge when an instruction cycle spans two clocks or more.
    cdsb_file_mem #(
        .ADDR_W (7),
        .DATA_W (8)
    ) u_mem (
        .clk     (CORE_CLK),
        .rd_en   (take_instr),
        .rd_addr (INSTR_CODE[`CDSB_FADDR_HI:`CDSB_FADDR_LO]),
        .rd_data (f_data),
        .wr_en   (mem_we_d),
        .wr_addr (faddr),
        .wr_data (mem_wd_d)
    );

    // A word is taken only on a start pulse; the exec pulse fires it.
    assign INSTR_READY = start_en;
    assign take_instr  = start_en & INSTR_VALID;
    assign fire        = exec_en & busy_q;

    // Fields of the latched word.
    assign op          = ir_q[`CDSB_OP_HI:`CDSB_OP_LO];
    assign dest        = ir_q[`CDSB_DEST_BIT];
    assign faddr       = ir_q[`CDSB_FADDR_HI:`CDSB_FADDR_LO];

    // Wrapping arithmetic on the operand read from the file registers.
    assign dec_val     = f_data - 8'h01;
    assign inc_val     = f_data + 8'h01;

    // Decode and compute the effect of the latched instruction.
    // Everything defaults to holding state, so a discarded slot or an
    // unknown op changes nothing but the counter step.
    always @*
    begin
        w_d       = W_REG;
        z_d       = ZERO_FLAG;
        pc_d      = pc_next(PROGRAM_COUNTER);
        mem_we_d  = 1'b0;
        mem_wd_d  = 8'h00;
        loaded_d  = 1'b0;
        skip_d    = 1'b0;
        unknown_d = 1'b0;
        res_d     = 8'h00;
        if (fire && !kill_q)
        begin
            if (ir_q[`CDSB_BR_HI:`CDSB_BR_LO] == `CDSB_OP_BRANCH)
            begin
                // Flags stay, counter is reloaded, next word taken is a no-op.
                pc_d = {PC_HIGH_LATCH[`CDSB_LATCH_HI:`CDSB_LATCH_LO],
                        ir_q[`CDSB_LIT_HI_BR:0]};
                loaded_d = 1'b1;
            end
            else
            begin
                case (op)
                    // Clear working register and set the zero flag.
                    `CDSB_OP_CLEAR_WORK:
                    begin
                        w_d = 8'h00;
                        z_d = 1'b1;
                    end
                    // Clear the addressed file register, set zero flag.
                    `CDSB_OP_CLEAR_FILE:
                    begin
                        mem_we_d = 1'b1;
                        mem_wd_d = 8'h00;
                        z_d      = 1'b1;
                    end
                    // Decrement, routed by destination; zero flag follows.
                    `CDSB_OP_DEC_FILE:
                    begin
                        res_d = dec_val;
                        z_d   = zero8(dec_val);
                        if (dest == `CDSB_DEST_FILE)
                        begin
                            mem_we_d = 1'b1;
                            mem_wd_d = dec_val;
                        end
                        else
                        begin
                            w_d = dec_val;
                        end
                    end
                    // Decrement, skip when zero; flags stay as they are.
                    `CDSB_OP_DEC_SKIP:
                    begin
                        res_d  = dec_val;
                        skip_d = zero8(dec_val);
                        if (dest == `CDSB_DEST_FILE)
                        begin
                            mem_we_d = 1'b1;
                            mem_wd_d = dec_val;
                        end
                        else
                        begin
                            w_d = dec_val;
                        end
                    end
                    // Increment, skip when zero; flags stay as they are.
                    `CDSB_OP_INC_SKIP:
                    begin
                        res_d  = inc_val;
                        skip_d = zero8(inc_val);
                        if (dest == `CDSB_DEST_FILE)
                        begin
                            mem_we_d = 1'b1;
                            mem_wd_d = inc_val;
                        end
                        else
                        begin
                            w_d = inc_val;
                        end
                    end
                    // Inclusive OR of the literal into working register.
                    `CDSB_OP_OR_LIT:
                    begin
                        res_d = W_REG | ir_q[`CDSB_LIT_HI:0];
                        w_d   = res_d;
                        z_d   = zero8(res_d);
                    end
                    // Outside the group: only the counter steps.
                    default:
                    begin
                        unknown_d = 1'b1;
                    end
                endcase
            end
        end
    end

    // Fetch side: latch the word and mark a slot to be discarded.
    // The pending no-op travels with the next word actually taken, so
    // idle slots between words never use it up.
    always @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            ir_q   <= {`CDSB_INSTR_W{1'b0}};
            busy_q <= 1'b0;
            kill_q <= 1'b0;
        end
        else if (take_instr)
        begin
            ir_q   <= INSTR_CODE;
            busy_q <= 1'b1;
            kill_q <= nop_pend_q;
        end
        else if (fire)
        begin
            busy_q <= 1'b0;
            kill_q <= 1'b0;
        end
    end

    // A pending no-op is armed by a branch or a taken skip.
    // It is armed at an exec edge and cleared at a take edge, which never
    // coincide while an instruction cycle spans two clocks.
    always @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            nop_pend_q <= 1'b0;
        end
        else if (fire && !kill_q && (loaded_d || skip_d))
        begin
            nop_pend_q <= 1'b1;
        end
        else if (take_instr)
        begin
            nop_pend_q <= 1'b0;
        end
    end

    // Architectural state and the visible result pulses.
    // Pulses are rewritten every clock so each stands for one clock only;
    // the file address and data hold until the next file write.
    always @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            W_REG           <= `CDSB_W_RESET;
            ZERO_FLAG       <= `CDSB_Z_RESET;
            PROGRAM_COUNTER <= `CDSB_PC_RESET;
            PC_LOADED       <= 1'b0;
            SKIP_TAKEN      <= 1'b0;
            DISCARDED       <= 1'b0;
            RETIRED         <= 1'b0;
            UNKNOWN_OP      <= 1'b0;
            FILE_WE         <= 1'b0;
            FILE_ADDR       <= 7'h00;
            FILE_WDATA      <= 8'h00;
        end
        else
        begin
            PC_LOADED  <= loaded_d;
            SKIP_TAKEN <= skip_d;
            DISCARDED  <= fire & kill_q;
            RETIRED    <= fire & ~kill_q & ~unknown_d;
            UNKNOWN_OP <= unknown_d;
            FILE_WE    <= mem_we_d;
            // Mirror the file write so it can be observed outside.
            if (mem_we_d)
            begin
                FILE_ADDR  <= faddr;
                FILE_WDATA <= mem_wd_d;
            end
            // State moves only at the exec edge of a busy slot.
            if (fire)
            begin
                W_REG           <= w_d;
                ZERO_FLAG       <= z_d;
                PROGRAM_COUNTER <= pc_d;
            end
        end
    end

endmodule

// ### cdsb_exec_asserts.sv
// Concurrent checks on the ports of the execution unit.
`include "cdsb_map.vh"
module cdsb_exec_asserts (
    input logic        CORE_CLK,
    input logic        RST,
    input logic        INSTR_VALID,
    input logic [13:0] INSTR_CODE,
    input logic [6:0]  PC_HIGH_LATCH,
    input logic        INSTR_READY,
    input logic [7:0]  W_REG,
    input logic        ZERO_FLAG,
    input logic [14:0] PROGRAM_COUNTER,
    input logic        PC_LOADED,
    input logic        SKIP_TAKEN,
    input logic        DISCARDED,
    input logic        RETIRED,
    input logic        UNKNOWN_OP,
    input logic        FILE_WE,
    input logic [6:0]  FILE_ADDR,
    input logic [7:0]  FILE_WDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] word_q;
    logic        take;
    logic [5:0]  op;
    logic [3:0]  lat_hi;
    logic [7:0]  res;

    // Decoded views of the word whose results are now showing.
    assign take = INSTR_READY && INSTR_VALID;
    assign op = word_q[13:8];
    assign lat_hi = PC_HIGH_LATCH[6:3];
    assign res = word_q[7] ? FILE_WDATA : W_REG;

    // Keeps the last taken word until its results have landed.
    always @(posedge CORE_CLK)
    begin
        if (take)
            word_q <= INSTR_CODE;
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    clear_work_a: assert property (
        take && INSTR_CODE[13:8] == `CDSB_OP_CLEAR_WORK |=> ##1
        DISCARDED || (W_REG == 8'h00 && ZERO_FLAG)) else $error("clear w bad");
    clear_file_a: assert property (
        RETIRED && op == `CDSB_OP_CLEAR_FILE |-> FILE_WE && ZERO_FLAG &&
        FILE_ADDR == word_q[6:0] && FILE_WDATA == 8'h00)
        else $error("clear file bad");
    dec_file_a: assert property (
        RETIRED && op == `CDSB_OP_DEC_FILE |-> FILE_WE == word_q[7] &&
        ZERO_FLAG == (res == 8'h00)) else $error("decrement result bad");
    skip_flag_a: assert property (
        RETIRED && (op == `CDSB_OP_DEC_SKIP || op == `CDSB_OP_INC_SKIP) |->
        $stable(ZERO_FLAG) && SKIP_TAKEN == (res == 8'h00))
        else $error("skip result bad");
    discard_a: assert property (
        DISCARDED |-> !RETIRED && !FILE_WE && $stable(W_REG) &&
        $stable(ZERO_FLAG)) else $error("discarded slot had an effect");
    branch_pc_a: assert property (
        RETIRED && word_q[13:11] == `CDSB_OP_BRANCH |-> PC_LOADED &&
        $stable(ZERO_FLAG) && PROGRAM_COUNTER == {$past(lat_hi), word_q[10:0]})
        else $error("branch target bad");
    or_lit_a: assert property (
        RETIRED && op == `CDSB_OP_OR_LIT |-> ZERO_FLAG == (W_REG == 8'h00) &&
        W_REG == ($past(W_REG) | word_q[7:0])) else $error("or literal bad");
    pc_step_a: assert property (
        DISCARDED || UNKNOWN_OP || (RETIRED && !PC_LOADED) |->
        PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 15'h0001)
        else $error("counter step bad");
    ready_beat_a: assert property (
        INSTR_READY |=> !INSTR_READY ##1 INSTR_READY)
        else $error("ready spacing bad");

    skip_c: cover property (SKIP_TAKEN);
    branch_c: cover property (PC_LOADED);
    discard_c: cover property (DISCARDED);
endmodule

bind cdsb_exec_core cdsb_exec_asserts u_cdsb_exec_asserts (
    .CORE_CLK        (CORE_CLK),
    .RST             (RST),
    .INSTR_VALID     (INSTR_VALID),
    .INSTR_CODE      (INSTR_CODE),
    .PC_HIGH_LATCH   (PC_HIGH_LATCH),
    .INSTR_READY     (INSTR_READY),
    .W_REG           (W_REG),
    .ZERO_FLAG       (ZERO_FLAG),
    .PROGRAM_COUNTER (PROGRAM_COUNTER),
    .PC_LOADED       (PC_LOADED),
    .SKIP_TAKEN      (SKIP_TAKEN),
    .DISCARDED       (DISCARDED),
    .RETIRED         (RETIRED),
    .UNKNOWN_OP      (UNKNOWN_OP),
    .FILE_WE         (FILE_WE),
    .FILE_ADDR       (FILE_ADDR),
    .FILE_WDATA      (FILE_WDATA)
);

// ### cdsb_tb.sv
// Self-checking bench for the execution unit with a reference model.
`include "cdsb_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CORE_CLK, RST, INSTR_VALID, INSTR_READY, ZERO_FLAG;
    logic        PC_LOADED, SKIP_TAKEN, DISCARDED, RETIRED, UNKNOWN_OP;
    logic        FILE_WE;
    logic [13:0] INSTR_CODE;
    logic [6:0]  PC_HIGH_LATCH, FILE_ADDR;
    logic [7:0]  W_REG, FILE_WDATA;
    logic [14:0] PROGRAM_COUNTER;
    int          bad_count, n_compared, w, z, pc, pend, i, k, a, b, op;
    int          mem [128];

    cdsb_exec_core u_cdsb_exec_core (
        .CORE_CLK        (CORE_CLK),
        .RST             (RST),
        .INSTR_VALID     (INSTR_VALID),
        .INSTR_CODE      (INSTR_CODE),
        .PC_HIGH_LATCH   (PC_HIGH_LATCH),
        .INSTR_READY     (INSTR_READY),
        .W_REG           (W_REG),
        .ZERO_FLAG       (ZERO_FLAG),
        .PROGRAM_COUNTER (PROGRAM_COUNTER),
        .PC_LOADED       (PC_LOADED),
        .SKIP_TAKEN      (SKIP_TAKEN),
        .DISCARDED       (DISCARDED),
        .RETIRED         (RETIRED),
        .UNKNOWN_OP      (UNKNOWN_OP),
        .FILE_WE         (FILE_WE),
        .FILE_ADDR       (FILE_ADDR),
        .FILE_WDATA      (FILE_WDATA)
    );

    // Core clock, 4 ns period.
    always #2 CORE_CLK = ~CORE_CLK;

    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input string n, input int e, input logic [14:0] g);
        n_compared++;
        if (g !== e[14:0])
        begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", n, e, g);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict;
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Offers one word, steps the model and compares every result.
    task automatic run(input logic [13:0] c);
        int f, d, r, we, sk, br, dc, un, lat, o;
        f = c[6:0];
        d = c[7];
        o = c[13:8];
        r = 0;
        we = 0;
        br = 0;
        un = 0;
        dc = pend;
        lat = $urandom % 128;
        // A word offered while not ready must be ignored.
        while (INSTR_READY !== 1'b1)
        begin
            INSTR_VALID = 1;
            INSTR_CODE = {`CDSB_OP_CLEAR_WORK, 8'hFF};
            @(negedge CORE_CLK);
        end
        INSTR_VALID = 1;
        INSTR_CODE = c;
        PC_HIGH_LATCH = lat;
        @(negedge CORE_CLK);
        INSTR_VALID = 0;
        @(negedge CORE_CLK);
        case (o)
            `CDSB_OP_CLEAR_WORK: d = 0;
            `CDSB_OP_CLEAR_FILE: d = 1;
            `CDSB_OP_DEC_FILE, `CDSB_OP_DEC_SKIP: r = (mem[f] + 255) % 256;
            `CDSB_OP_INC_SKIP: r = (mem[f] + 1) % 256;
            `CDSB_OP_OR_LIT: r = w | c[7:0];
            default: un = 1;
        endcase
        if (o == `CDSB_OP_OR_LIT)
            d = 0;
        sk = (o == `CDSB_OP_DEC_SKIP || o == `CDSB_OP_INC_SKIP) && r == 0;
        pc = (pc + 1) % 32768;
        if (dc)
        begin
            {un, sk} = 2'b00;
        end
        else if (c[13:11] == `CDSB_OP_BRANCH)
        begin
            un = 0;
            br = 1;
            pc = ((lat >> 3) % 16) * 2048 + c[10:0];
        end
        else if (!un)
        begin
            we = d;
            if (d)
                mem[f] = r;
            else
                w = r;
            if (!sk && o != `CDSB_OP_DEC_SKIP && o != `CDSB_OP_INC_SKIP)
                z = (r == 0);
        end
        pend = br | sk;
        chk("w", w, W_REG);
        chk("z", z, ZERO_FLAG);
        chk("pc", pc, PROGRAM_COUNTER);
        chk("we", we, FILE_WE);
        if (we)
            chk("addr", f, FILE_ADDR);
        if (we)
            chk("wdata", r, FILE_WDATA);
        chk("skip", sk, SKIP_TAKEN);
        chk("branch", br, PC_LOADED);
        chk("discard", dc, DISCARDED);
        chk("unknown", un, UNKNOWN_OP);
        chk("retired", !dc && !un, RETIRED);
    endtask

    // Reset, clear every file register, then a random instruction stream.
    initial
    begin
        CORE_CLK = 0;
        RST = 1;
        INSTR_VALID = 0;
        INSTR_CODE = 0;
        PC_HIGH_LATCH = 0;
        void'($urandom(44190));
        repeat (8) @(negedge CORE_CLK);
        RST = 0;
        for (i = 0; i < 128; i++)
            run({`CDSB_OP_CLEAR_FILE, 1'b1, i[6:0]});
        for (i = 0; i < 700; i++)
        begin
            k = $urandom % 8;
            a = ($urandom % 2) ? $urandom % 4 : 124 + $urandom % 4;
            a = a + 128 * ($urandom % 2);
            b = $urandom;
            op = `CDSB_OP_CLEAR_WORK + k;
            if (k < 6)
                run({op[5:0], a[7:0]});
            else if (k == 6)
                run({`CDSB_OP_BRANCH, b[10:0]});
            else
                run({6'h00, a[7:0]});
            // Idle gaps of up to three clocks leave whole slots unused.
            if ($urandom % 4 == 0)
                repeat (1 + $urandom % 3) @(negedge CORE_CLK);
        end
        print_verdict;
    end

    // Watchdog against a hang.
    initial
    begin
        repeat (20000) @(posedge CORE_CLK);
        bad_count++;
        print_verdict;
    end
endmodule
